// >>> rtl/ext_data_mem_port.sv
// Purpose: Forms external move addresses and runs on-chip or off-chip access.
// Assumes: Requests are one-cycle pulses and only arrive while idle.
// Notes: Pin output mode and port latch muxing live outside this block.
`timescale 1ns/100ps
`default_nettype none
module ext_data_mem_port
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic mux_form_select_i,
  input wire logic [1:0] mem_mode_i,
  input wire logic [1:0] ale_width_i,
  input wire logic flash_target_i,
  input wire logic dph_we_i,
  input wire logic dpl_we_i,
  input wire logic page_we_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic req_i,
  input wire logic req_we_i,
  input wire logic req_form16_i,
  input wire logic req_ptr_sel_i,
  input wire logic [7:0] r0_i,
  input wire logic [7:0] r1_i,
  input wire logic [7:0] req_wdata_i,
  input wire logic [7:0] p1_i,
  output logic [7:0] data_pointer_high_o,
  output logic [7:0] data_pointer_low_o,
  output logic [7:0] ext_addr_high_page_o,
  output logic [7:0] rdata_o,
  output logic done_o,
  output logic busy_o,
  output logic flash_wr_o,
  output logic [15:0] flash_addr_o,
  output ext_mem_pkg::pins_t pins_o
);

  ext_mem_pkg::state_t state;
  ext_mem_pkg::state_t next_state;
  ext_mem_pkg::access_t acc;
  ext_mem_pkg::access_t next_acc;
  ext_mem_pkg::pins_t next_pins;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [7:0] ram [ext_mem_pkg::ONCHIP_BYTES];
  logic [15:0] eff_addr;
  logic off_chip;
  logic is_mux;

  function automatic logic goes_off_chip(input logic [1:0] mode,
                                         input logic [15:0] addr);
    logic below;
    below = addr < ext_mem_pkg::ONCHIP_LIMIT;
    case (ext_mem_pkg::mem_mode_t'(mode))
      ext_mem_pkg::MODE_ONCHIP: goes_off_chip = 1'b0;
      ext_mem_pkg::MODE_SPLIT_NOBANK: goes_off_chip = !below;
      ext_mem_pkg::MODE_SPLIT_BANK: goes_off_chip = !below;
      ext_mem_pkg::MODE_OFFCHIP: goes_off_chip = 1'b1;
      default: goes_off_chip = 1'b1;
    endcase
  endfunction : goes_off_chip

  assign eff_addr = req_form16_i ?
    {data_pointer_high_o, data_pointer_low_o} :
    {ext_addr_high_page_o,
     req_ptr_sel_i ? r1_i : r0_i};
  assign off_chip = goes_off_chip(mem_mode_i, eff_addr);
  assign is_mux = !mux_form_select_i;

  // Data pointer halves are written separately; a same-cycle pair loads one byte into both.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      data_pointer_high_o <= ext_mem_pkg::DP_RESET;
      data_pointer_low_o <= ext_mem_pkg::DP_RESET;
      ext_addr_high_page_o <= ext_mem_pkg::PAGE_RESET;
    end
    else
    begin
      if (dph_we_i)
        data_pointer_high_o <= sfr_wdata_i;
      if (dpl_we_i)
        data_pointer_low_o <= sfr_wdata_i;
      if (page_we_i)
        ext_addr_high_page_o <= sfr_wdata_i;
    end
  end

  // On-chip RAM has no reset; its contents are undefined until written.
  always_ff @(posedge clk_i)
  begin
    if (req_i && state == ext_mem_pkg::ST_IDLE && req_we_i &&
        !flash_target_i && !off_chip)
      ram[eff_addr[ext_mem_pkg::ONCHIP_AW-1:0]] <= req_wdata_i;
  end

  // The pins are built from the access being taken, so the first claimed
  // cycle already carries the new address and not the previous one.
  always_comb
  begin
    next_acc = acc;
    if (req_i && state == ext_mem_pkg::ST_IDLE)
    begin
      next_acc.we = req_we_i;
      next_acc.addr = eff_addr;
      next_acc.wdata = req_wdata_i;
      // Without bank select an 8-bit form move leaves the high byte with the port latches.
      next_acc.drive_hi = !(mem_mode_i == ext_mem_pkg::MODE_SPLIT_NOBANK &&
                            !req_form16_i);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      acc <= '0;
    else
      acc <= next_acc;
  end

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      ext_mem_pkg::ST_IDLE:
        if (req_i && !(flash_target_i && req_we_i) && off_chip)
        begin
          next_state = ext_mem_pkg::ST_ADDR;
          next_cnt = is_mux ? {2'b00, ale_width_i} : 4'h0;
        end
      ext_mem_pkg::ST_ADDR:
        if (cnt == 4'h0)
          next_state = ext_mem_pkg::ST_ALE_LOW;
        else
          next_cnt = cnt - 4'h1;
      ext_mem_pkg::ST_ALE_LOW:
      begin
        next_state = ext_mem_pkg::ST_STROBE;
        next_cnt = ext_mem_pkg::STROBE_CYCLES - 4'h1;
      end
      ext_mem_pkg::ST_STROBE:
        if (cnt == 4'h0)
          next_state = ext_mem_pkg::ST_HOLD;
        else
          next_cnt = cnt - 4'h1;
      ext_mem_pkg::ST_HOLD:
        next_state = ext_mem_pkg::ST_IDLE;
      default:
        next_state = ext_mem_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state <= ext_mem_pkg::ST_IDLE;
      cnt <= 4'h0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // Pin values follow the next state so they leave flip-flops cleanly.
  always_comb
  begin
    next_pins = '0;
    next_pins.rd_n = 1'b1;
    next_pins.wr_n = 1'b1;
    if (next_state != ext_mem_pkg::ST_IDLE)
    begin
      next_pins.claim = 1'b1;
      next_pins.strobe_oe = 1'b1;
      next_pins.ale_oe = is_mux;
      next_pins.p3_hi = next_acc.addr[11:8];
      next_pins.p4_addr = next_acc.addr[15:12];
      next_pins.p3_hi_oe = next_acc.drive_hi;
      next_pins.p4_addr_oe = next_acc.drive_hi;
      if (is_mux)
      begin
        if (next_state == ext_mem_pkg::ST_ADDR)
        begin
          next_pins.ale = 1'b1;
          next_pins.p1 = next_acc.addr[7:0];
          next_pins.p1_oe = 1'b1;
        end
        else if (next_state == ext_mem_pkg::ST_ALE_LOW)
        begin
          next_pins.p1 = next_acc.addr[7:0];
          next_pins.p1_oe = 1'b1;
        end
        else
        begin
          next_pins.p1 = next_acc.wdata;
          next_pins.p1_oe = next_acc.we;
        end
      end
      else
      begin
        next_pins.p2 = next_acc.addr[7:0];
        next_pins.p2_oe = 1'b1;
        next_pins.p1 = next_acc.wdata;
        next_pins.p1_oe = next_acc.we;
      end
      if (next_state == ext_mem_pkg::ST_STROBE)
      begin
        next_pins.rd_n = next_acc.we;
        next_pins.wr_n = !next_acc.we;
      end
    end
  end

  // Only drive levels and enables leave here; open-drain versus push-pull
  // stays with the port output mode logic.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pins_o <= '0;
      pins_o.rd_n <= 1'b1;
      pins_o.wr_n <= 1'b1;
    end
    else
      pins_o <= next_pins;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rdata_o <= 8'h00;
      done_o <= 1'b0;
      busy_o <= 1'b0;
      flash_wr_o <= 1'b0;
      flash_addr_o <= 16'h0000;
    end
    else
    begin
      done_o <= 1'b0;
      flash_wr_o <= 1'b0;
      busy_o <= next_state != ext_mem_pkg::ST_IDLE;
      if (req_i && state == ext_mem_pkg::ST_IDLE)
      begin
        if (flash_target_i && req_we_i)
        begin
          flash_wr_o <= 1'b1;
          flash_addr_o <= eff_addr;
          done_o <= 1'b1;
        end
        else if (!off_chip)
        begin
          if (!req_we_i)
            rdata_o <= ram[eff_addr[ext_mem_pkg::ONCHIP_AW-1:0]];
          done_o <= 1'b1;
        end
      end
      else if (state == ext_mem_pkg::ST_STROBE && cnt == 4'h0)
      begin
        if (!acc.we)
          rdata_o <= p1_i;
      end
      else if (state == ext_mem_pkg::ST_HOLD)
        done_o <= 1'b1;
    end
  end

endmodule : ext_data_mem_port
`default_nettype wire

// >>> shared/ext_mem_pkg.sv
// Purpose: Constants and types for the external data memory port.
// Assumes: One 50 MHz clock, active-low asynchronous reset.
// Notes: Strobe timing is fixed here because no timing register exists.
//
// Contract
// - 1k on-chip RAM in external space
// - 8-bit form: high byte from page register
// - 16-bit form: data pointer is address
// - Data pointer split into high/low bytes
// - 8-bit form: low byte from R0/
// - Moves target data RAM, not flash; writes go to flash while flash_target_i is set
// - Drive pins only during off-chip move
// - Input pins have drivers turned off
// - Output mode untouched by interface
// - Ports 1,3,4 always; port 2 non-multiplexed; ports 3,4 are left undriven for 8-bit form moves in MODE_SPLIT_NOBANK
// - Four memory modes supported
// - Multiplexed: data shares low address pins
// - Latch strobe high with address, then low
// - Config bit selects multiplexed form
package ext_mem_pkg;

  localparam int unsigned ONCHIP_BYTES = 1024;
  localparam int unsigned ONCHIP_AW = 10;
  localparam logic [15:0] ONCHIP_LIMIT = 16'h0400;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] DP_RESET = 8'h00;
  localparam logic [1:0] ALE_WIDTH_RESET = 2'h3;
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned STROBE_NS = 40;
  localparam logic [3:0] STROBE_CYCLES =
    4'((STROBE_NS * CLK_MHZ + 999) / 1000);

  typedef enum logic [1:0]
  {
    MODE_ONCHIP = 2'b00,
    MODE_SPLIT_NOBANK = 2'b01,
    MODE_SPLIT_BANK = 2'b10,
    MODE_OFFCHIP = 2'b11
  } mem_mode_t;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ALE_LOW = 3'b010,
    ST_STROBE = 3'b011,
    ST_HOLD = 3'b100
  } state_t;

  typedef struct packed
  {
    logic we;
    logic drive_hi;
    logic [15:0] addr;
    logic [7:0] wdata;
  } access_t;

  typedef struct packed
  {
    logic [7:0] p1;
    logic p1_oe;
    logic [7:0] p2;
    logic p2_oe;
    logic [3:0] p3_hi;
    logic p3_hi_oe;
    logic [3:0] p4_addr;
    logic p4_addr_oe;
    logic rd_n;
    logic wr_n;
    logic strobe_oe;
    logic ale;
    logic ale_oe;
    logic claim;
  } pins_t;

endpackage : ext_mem_pkg

// >>> tb/ext_data_mem_port_asserts.sv
// Purpose: Port properties of the external data memory port.
// Assumes: One clock domain.
// Notes: Off-chip latency is checked as a window.
`timescale 1ns/100ps
`default_nettype none
module ext_data_mem_port_asserts
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic mux_form_select_i,
  input wire logic dph_we_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic [7:0] data_pointer_high_o,
  input wire ext_mem_pkg::pins_t pins_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  idle_strobe_a:
    assert property (!pins_o.claim |-> pins_o.rd_n && pins_o.wr_n)
    else $error("strobe while idle");
  read_float_a:
    assert property (!pins_o.rd_n |-> !pins_o.p1_oe)
    else $error("data driven in read");
  claim_busy_a:
    assert property (pins_o.claim |-> busy_o)
    else $error("claim without busy");
  release_pins_a:
    assert property (!pins_o.claim |-> !pins_o.p1_oe && !pins_o.p2_oe)
    else $error("pins driven while idle");
  mux_no_p2_a:
    assert property (!mux_form_select_i |-> !pins_o.p2_oe)
    else $error("port 2 used in mux form");
  strobe_ale_a:
    assert property (!(pins_o.rd_n && pins_o.wr_n) |-> !pins_o.ale)
    else $error("strobe with latch open");
  done_window_a:
    assert property ($rose(busy_o) |-> ##[4:9] done_o)
    else $error("off-chip move too slow");
  dp_load_a:
    assert property (dph_we_i |=> data_pointer_high_o == $past(sfr_wdata_i))
    else $error("pointer high not loaded");
  cover property (!pins_o.rd_n);
  cover property (!pins_o.wr_n);
  cover property (done_o && !busy_o);
endmodule : ext_data_mem_port_asserts
bind ext_data_mem_port ext_data_mem_port_asserts chk_u (.clk_i, .rstn_i,
  .mux_form_select_i, .dph_we_i, .sfr_wdata_i, .busy_o, .done_o,
  .data_pointer_high_o, .pins_o);
`default_nettype wire

// >>> tb/ext_sram_model.sv
// Purpose: Off-chip SRAM behind an address latch.
// Assumes: Pins settle before each rising edge.
// Notes: A released data bus shows the inverted last byte.
`timescale 1ns/100ps
`default_nettype none
module ext_sram_model
(
  input wire logic clk_i,
  input wire logic nonmux_i,
  input wire ext_mem_pkg::pins_t pins_i,
  output logic [7:0] p1_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] lo;
  logic [7:0] last = 8'h00;
  logic [15:0] a;
  logic rd_seen_n;
  logic wr_seen_n;
  // Outside a move the strobe pins fall back to latches parked high.
  assign rd_seen_n = pins_i.claim ? pins_i.rd_n : 1'b1;
  assign wr_seen_n = pins_i.claim ? pins_i.wr_n : 1'b1;
  assign a = {pins_i.p4_addr, pins_i.p3_hi, nonmux_i ? pins_i.p2 : lo};
  // Pins are push-pull, so every driven level is taken as it stands.
  assign p1_o = !rd_seen_n ? mem[a] : ~last;
  always_ff @(posedge clk_i)
  begin
    if (pins_i.ale_oe && pins_i.ale)
      lo <= pins_i.p1;
    if (!wr_seen_n)
      mem[a] <= pins_i.p1;
    if (!rd_seen_n)
      last <= mem[a];
  end
endmodule : ext_sram_model
`default_nettype wire

// >>> tb/tb_ext_data_mem_port.sv
// Purpose: Directed test of the external data memory port.
// Assumes: Inputs change on falling edges.
// Notes: Every move must finish within a bounded wait.
`timescale 1ns/100ps
`default_nettype none
module tb_ext_data_mem_port;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic mux_form_select_i, flash_target_i, dph_we_i, dpl_we_i, page_we_i;
  logic req_i, req_we_i, req_form16_i, req_ptr_sel_i, done_o, busy_o;
  logic flash_wr_o;
  logic [1:0] mem_mode_i, ale_width_i;
  logic [7:0] sfr_wdata_i, r0_i, r1_i, req_wdata_i, p1_i, rdata_o;
  logic [7:0] data_pointer_high_o, data_pointer_low_o, ext_addr_high_page_o;
  logic [15:0] flash_addr_o;
  ext_mem_pkg::pins_t pins_o;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  always #10 clk_i = ~clk_i;
  ext_data_mem_port uut (.clk_i, .rstn_i, .mux_form_select_i, .mem_mode_i,
    .ale_width_i, .flash_target_i, .dph_we_i, .dpl_we_i, .page_we_i,
    .sfr_wdata_i, .req_i, .req_we_i, .req_form16_i, .req_ptr_sel_i, .r0_i,
    .r1_i, .req_wdata_i, .p1_i, .data_pointer_high_o, .data_pointer_low_o,
    .ext_addr_high_page_o, .rdata_o, .done_o, .busy_o, .flash_wr_o,
    .flash_addr_o, .pins_o);
  ext_sram_model mdl (.clk_i, .nonmux_i(mux_form_select_i), .pins_i(pins_o),
    .p1_o(p1_i));
  task automatic report_and_stop;
    if (num_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(negedge clk_i);
    {dph_we_i, dpl_we_i, page_we_i} = s;
    sfr_wdata_i = d;
    @(negedge clk_i);
    {dph_we_i, dpl_we_i, page_we_i} = 3'h0;
  endtask : wr
  task automatic mv(input logic we, f16, sel, input logic [7:0] wd);
    @(negedge clk_i);
    {req_i, req_we_i, req_form16_i, req_ptr_sel_i} = {1'b1, we, f16, sel};
    req_wdata_i = wd;
    @(negedge clk_i);
    req_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 30)
    begin
      @(negedge clk_i);
      n++;
    end
    chk(16'(done_o), 16'h1);
  endtask : mv
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      num_errors++;
      report_and_stop();
    end
  end
  initial
  begin
    {mux_form_select_i, flash_target_i, dph_we_i, dpl_we_i, page_we_i} = '0;
    {req_i, req_we_i, req_form16_i, req_ptr_sel_i} = '0;
    {mem_mode_i, ale_width_i, sfr_wdata_i, req_wdata_i} = '0;
    r0_i = 8'h77;
    r1_i = 8'h34;
    repeat (3) @(negedge clk_i);
    chk(16'(pins_o.rd_n & pins_o.wr_n), 16'h1);
    rstn_i = 1'b1;
    wr(3'h4, 8'h12);
    wr(3'h2, 8'h34);
    chk({data_pointer_high_o, data_pointer_low_o}, 16'h1234);
    wr(3'h1, 8'h02);
    chk(16'(ext_addr_high_page_o), 16'h0002);
    mv(1'b1, 1'b1, 1'b0, 8'ha5);
    chk(16'(n), 16'h0);
    mv(1'b0, 1'b0, 1'b1, 8'h00);
    chk(16'(rdata_o), 16'h00a5);
    mem_mode_i = 2'h3;
    ale_width_i = 2'h3;
    mv(1'b1, 1'b1, 1'b0, 8'h3c);
    chk(16'(mdl.mem[16'h1234]), 16'h003c);
    wr(3'h1, 8'h12);
    mv(1'b0, 1'b0, 1'b1, 8'h00);
    chk(16'(rdata_o), 16'h003c);
    mux_form_select_i = 1'b1;
    wr(3'h2, 8'h40);
    mv(1'b1, 1'b1, 1'b0, 8'hc3);
    chk(16'(mdl.mem[16'h1240]), 16'h00c3);
    mv(1'b0, 1'b1, 1'b0, 8'h00);
    chk(16'(rdata_o), 16'h00c3);
    mem_mode_i = 2'h2;
    wr(3'h4, 8'h01);
    wr(3'h2, 8'h00);
    mv(1'b1, 1'b1, 1'b0, 8'h11);
    chk(16'(n), 16'h0);
    mem_mode_i = 2'h1;
    mv(1'b0, 1'b1, 1'b0, 8'h00);
    chk({8'(n), rdata_o}, 16'h0011);
    mem_mode_i = 2'h0;
    flash_target_i = 1'b1;
    mv(1'b1, 1'b1, 1'b0, 8'h5e);
    chk(flash_addr_o, 16'h0100);
    chk(16'(flash_wr_o), 16'h1);
    flash_target_i = 1'b0;
    mv(1'b0, 1'b1, 1'b0, 8'h00);
    chk(16'(rdata_o), 16'h0011);
    report_and_stop();
  end
endmodule : tb_ext_data_mem_port
`default_nettype wire
